// file: core/adpcm_codec_control_regs.sv
`timescale 1ns/10ps
// Overview of operation
// R1 - power-down bit powers whole device down
// R2 - pin held high; power-down ORs inverted pin
// R3 - controller writes zero to all test bits
// R4 - powerdown pin low loads all initial values
// R5 - width field selects 4, 8, 3, 2 bits
// R6 - reset bits reset transmit and receive coder
// R7 - both coder reset bits set together
// R8 - coder reset held one sample period
// R9 - mute bits mute transmit and receive data
// R10 - pad bit inserts 12 dB receive loss
// R11 - pcm disable bits turn paths off
// R12 - three-bit gains, 2 dB steps
// R13 - sidetone code zero off, else gain
// R14 - cutoff select picks 0.0275 or 0.0200
// R15 - hpf disable bit bypasses high-pass filter
// R16 - burst or continuous shift clock accepted
// R17 - control frames of 12 or 16 bits
// R18 - writes leave other registers and fields intact
module adpcm_codec_control_regs (
	input  wire logic                              clk_sys,
	input  wire logic                              rst_b,
	input  wire logic                              powerdown_reset_pin_b,
	input  wire logic                              shift_clock_in,
	input  wire logic                              serial_control_input,
	input  wire logic                              controlSelect_b,
	output logic                                   serialControlOutput,
	output logic                                   serialOutputEn_b,
	output logic                                   devicePowerDown,
	output logic      [adpcm_ctrl_pkg::BITS_W-1:0] adpcmBitsPerSample,
	output logic                                   txCoderReset,
	output logic                                   rxCoderReset,
	output logic                                   txAdpcmMute,
	output logic                                   rxAdpcmMute,
	output logic                                   rxPadInsert,
	output logic                                   txPcmEnable,
	output logic                                   rxPcmEnable,
	output logic      [adpcm_ctrl_pkg::GAIN_W-1:0] txGainCode,
	output logic      [adpcm_ctrl_pkg::GAIN_W-1:0] rxGainCode,
	output logic                                   sidetoneOn,
	output logic      [adpcm_ctrl_pkg::GAIN_W-1:0] sidetoneGainCode,
	output logic                                   hpfCutoffLow,
	output logic                                   hpfEnable
);
	import adpcm_ctrl_pkg::*;

	// =============================================================
	// pin synchronisation and frame receiver
	logic [PIN_W-1:0]      pinsSync;
	logic                  sclkSync;
	logic                  dinSync;
	logic                  selSync_b;
	logic                  pdnSync_b;
	logic [ADDR_W-1:0]     headerAddr;
	logic                  frameDone;
	logic [FRAME_MAIN-1:0] frameWord;
	logic [REG_W-1:0]      readByte;
	logic                  rxSerialOut;
	logic                  rxSerialEn_b;

	pin_synchroniser #(
		.WIDTH   (PIN_W),
		.RST_VAL (PIN_SYNC_RST)
	) u_pins (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.pinsIn  ({powerdown_reset_pin_b, controlSelect_b, serial_control_input,
			shift_clock_in}),
		.pinsOut (pinsSync)
	);

	assign sclkSync  = pinsSync[0];
	assign dinSync   = pinsSync[1];
	assign selSync_b = pinsSync[2];
	assign pdnSync_b = pinsSync[3];

	serial_frame_rx u_rx (
		.clk_sys       (clk_sys),
		.rst_b         (rst_b),
		.sclkSync      (sclkSync),
		.dinSync       (dinSync),
		.selSync_b     (selSync_b),
		.readByte      (readByte),
		.headerAddr    (headerAddr),
		.frameDone     (frameDone),
		.frameWord     (frameWord),
		.serialOut     (rxSerialOut),
		.serialOutEn_b (rxSerialEn_b)
	);

	// =============================================================
	// register and output state
	typedef struct packed {
		logic [REG_W-1:0]  powerReg;
		logic [REG_W-1:0]  modeReg;
		logic [REG_W-1:0]  pathReg;
		logic [REG_W-1:0]  sideReg;
		logic              sdo;
		logic              sdoEn_b;
		logic              pdnOut;
		logic [BITS_W-1:0] bitsOut;
		logic              txRst;
		logic              rxRst;
		logic              txMute;
		logic              rxMute;
		logic              rxPad;
		logic              txPcmOn;
		logic              rxPcmOn;
		logic [GAIN_W-1:0] txGain;
		logic [GAIN_W-1:0] rxGain;
		logic              stOn;
		logic [GAIN_W-1:0] stGain;
		logic              hpfLow;
		logic              hpfOn;
	} ctrl_s;

	ctrl_s s;
	ctrl_s n;

	logic              frameWrite;
	logic [ADDR_W-1:0] frameAddr;
	logic [REG_W-1:0]  frameData;

	assign frameWrite = frameDone & ~frameWord[FRM_RW_BIT];
	assign frameAddr  = frameWord[FRM_ADDR_MSB:FRM_ADDR_LSB];
	assign frameData  = frameWord[FRM_DATA_MSB:0];

	// read-back mux; unmapped addresses read zero
	always_comb begin
		case (headerAddr)
			ADDR_POWER: readByte = s.powerReg;
			ADDR_MODE:  readByte = s.modeReg;
			ADDR_PATH:  readByte = s.pathReg;
			ADDR_SIDE:  readByte = s.sideReg;
			default:    readByte = '0;
		endcase
	end

	// code width to bits per sample
	function automatic logic [BITS_W-1:0] widthBits(input logic [1:0] code);
		// R5 width decode
		case (adpcm_width_e'(code))
			WIDTH_4BIT: widthBits = BITS_4;
			WIDTH_8BIT: widthBits = BITS_8;
			WIDTH_3BIT: widthBits = BITS_3;
			WIDTH_2BIT: widthBits = BITS_2;
			default:    widthBits = BITS_4;
		endcase
	endfunction

	// =============================================================
	// next state
	always_comb begin
		n = s;
		if (!pdnSync_b) begin
			// R4 pin reset loads
			n.powerReg = POWER_RST;
			n.modeReg  = MODE_RST;
			n.pathReg  = PATH_RST;
			n.sideReg  = SIDE_RST;
		end else if (frameWrite) begin
			// R18 only addressed register
			case (frameAddr)
				ADDR_POWER: n.powerReg = frameData;
				ADDR_MODE:  n.modeReg  = frameData;
				ADDR_PATH:  n.pathReg  = frameData;
				ADDR_SIDE:  n.sideReg  = frameData;
				default:    n.powerReg = s.powerReg;
			endcase
		end

		// readback pin stays passive unless the frame's first bit is 1, which is the read bit only in a 12-bit frame
		n.sdo     = rxSerialOut;
		n.sdoEn_b = rxSerialEn_b;

		// R1 R2 pin ORed in
		n.pdnOut  = s.powerReg[PWR_PDN_BIT] | ~pdnSync_b;
		n.bitsOut = widthBits({s.modeReg[MODE_HI_BIT], s.modeReg[MODE_LO_BIT]});
		// R6 coder resets follow bits; width of pulse is software's duty
		n.txRst   = s.modeReg[MODE_TXRST];
		n.rxRst   = s.modeReg[MODE_RXRST];
		// R9 mute controls
		n.txMute  = s.modeReg[MODE_TXMUTE];
		n.rxMute  = s.modeReg[MODE_RXMUTE];
		// R10 receive pad
		n.rxPad   = s.modeReg[MODE_RXPAD];
		// R11 pcm path enables, inverted sense
		n.txPcmOn = ~s.pathReg[PATH_TXOFF];
		n.rxPcmOn = ~s.pathReg[PATH_RXOFF];
		// R12 gain codes
		n.txGain  = s.pathReg[PATH_TXG_LSB +: GAIN_W];
		n.rxGain  = s.pathReg[PATH_RXG_LSB +: GAIN_W];
		// R13 sidetone off at zero
		n.stGain  = s.sideReg[SIDE_G_LSB +: GAIN_W];
		n.stOn    = s.sideReg[SIDE_G_LSB +: GAIN_W] != SIDETONE_OFF;
		// R14 cutoff select
		n.hpfLow  = s.sideReg[SIDE_HPF_CUT];
		// R15 filter bypass
		n.hpfOn   = ~s.sideReg[SIDE_HPF_DIS];
	end

	// power-down output set at reset, held until the synchronised pin reads high on the third edge after release
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s <= '{powerReg: POWER_RST, modeReg: MODE_RST, pathReg: PATH_RST,
				sideReg: SIDE_RST, sdo: 1'b0, sdoEn_b: 1'b1, pdnOut: 1'b1,
				bitsOut: BITS_4, txRst: 1'b0, rxRst: 1'b0, txMute: 1'b0,
				rxMute: 1'b0, rxPad: 1'b0, txPcmOn: 1'b1, rxPcmOn: 1'b1,
				txGain: PATH_RST[PATH_TXG_LSB +: GAIN_W],
				rxGain: PATH_RST[PATH_RXG_LSB +: GAIN_W],
				stOn: 1'b0, stGain: SIDETONE_OFF, hpfLow: 1'b0, hpfOn: 1'b1};
		end else begin
			s <= n;
		end
	end

	// =============================================================
	// output ports
	assign serialControlOutput = s.sdo;
	assign serialOutputEn_b    = s.sdoEn_b;
	assign devicePowerDown     = s.pdnOut;
	assign adpcmBitsPerSample  = s.bitsOut;
	assign txCoderReset        = s.txRst;
	assign rxCoderReset        = s.rxRst;
	assign txAdpcmMute         = s.txMute;
	assign rxAdpcmMute         = s.rxMute;
	assign rxPadInsert         = s.rxPad;
	assign txPcmEnable         = s.txPcmOn;
	assign rxPcmEnable         = s.rxPcmOn;
	assign txGainCode          = s.txGain;
	assign rxGainCode          = s.rxGain;
	assign sidetoneOn          = s.stOn;
	assign sidetoneGainCode    = s.stGain;
	assign hpfCutoffLow        = s.hpfLow;
	assign hpfEnable           = s.hpfOn;

	// =============================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence wrFrame(logic [ADDR_W-1:0] a);
		frameWrite && frameAddr == a && pdnSync_b;
	endsequence

	sequence settled;
		pdnSync_b ##1 pdnSync_b;
	endsequence

	pinResetLoad_a: assert property (!pdnSync_b |=> s.powerReg == POWER_RST // R4
		&& s.modeReg == MODE_RST && s.pathReg == PATH_RST && s.sideReg == SIDE_RST)
		else $error("registers not at initial values after pin reset");

	powerDownWr_a: assert property (wrFrame(ADDR_POWER) ##1 settled // R1
		|-> devicePowerDown == $past(frameData[PWR_PDN_BIT], 2))
		else $error("power-down output does not follow written bit");

	pinPowerDown_a: assert property (!pdnSync_b |=> devicePowerDown) // R2
		else $error("power-down pin low did not power down");

	widthDecode_a: assert property (wrFrame(ADDR_MODE) ##1 settled // R5
		|-> adpcmBitsPerSample == widthBits($past(frameData[MODE_HI_BIT:MODE_LO_BIT], 2)))
		else $error("bits per sample wrong for written width code");

	coderReset_a: assert property (wrFrame(ADDR_MODE) ##1 settled // R6
		|-> txCoderReset == $past(frameData[MODE_TXRST], 2)
		&& rxCoderReset == $past(frameData[MODE_RXRST], 2))
		else $error("coder reset outputs do not follow register");

	muteOut_a: assert property (wrFrame(ADDR_MODE) ##1 settled // R9
		|-> txAdpcmMute == $past(frameData[MODE_TXMUTE], 2)
		&& rxAdpcmMute == $past(frameData[MODE_RXMUTE], 2))
		else $error("mute outputs do not follow register");

	rxPad_a: assert property (wrFrame(ADDR_MODE) ##1 settled // R10
		|-> rxPadInsert == $past(frameData[MODE_RXPAD], 2))
		else $error("receive pad output wrong");

	pcmEnable_a: assert property (wrFrame(ADDR_PATH) ##1 settled // R11
		|-> txPcmEnable != $past(frameData[PATH_TXOFF], 2)
		&& rxPcmEnable != $past(frameData[PATH_RXOFF], 2))
		else $error("pcm enable sense wrong");

	pathGain_a: assert property (wrFrame(ADDR_PATH) ##1 settled // R12
		|-> txGainCode == $past(frameData[PATH_TXG_LSB +: GAIN_W], 2)
		&& rxGainCode == $past(frameData[PATH_RXG_LSB +: GAIN_W], 2))
		else $error("gain codes do not follow register");

	sidetoneOff_a: assert property (wrFrame(ADDR_SIDE) ##1 settled // R13
		|-> sidetoneOn == ($past(frameData[SIDE_G_LSB +: GAIN_W], 2) != SIDETONE_OFF)
		&& sidetoneGainCode == $past(frameData[SIDE_G_LSB +: GAIN_W], 2))
		else $error("sidetone enable disagrees with written gain code");

	hpfSelect_a: assert property (wrFrame(ADDR_SIDE) ##1 settled // R14
		|-> hpfCutoffLow == $past(frameData[SIDE_HPF_CUT], 2))
		else $error("cutoff select output wrong");

	hpfBypass_a: assert property (wrFrame(ADDR_SIDE) ##1 settled // R15
		|-> hpfEnable != $past(frameData[SIDE_HPF_DIS], 2))
		else $error("filter bypass sense wrong");

	othersKept_a: assert property (wrFrame(ADDR_MODE) |=> $stable(s.powerReg) // R18
		&& $stable(s.pathReg) && $stable(s.sideReg))
		else $error("write disturbed another register");
endmodule // adpcm_codec_control_regs

// file: core/pin_synchroniser.sv
`timescale 1ns/10ps
// =============================================================
// two flip-flop synchroniser for asynchronous pins
module pin_synchroniser #(
	parameter int                WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] pinsIn,
	output logic      [WIDTH-1:0] pinsOut
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_s;

	sync_s stateReg;
	sync_s stateNext;

	// first stage feeds only the second stage
	always_comb begin
		stateNext        = stateReg;
		stateNext.stage1 = pinsIn;
		stateNext.stage2 = stateReg.stage1;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			stateReg <= {RST_VAL, RST_VAL};
		end else begin
			stateReg <= stateNext;
		end
	end

	assign pinsOut = stateReg.stage2;
endmodule // pin_synchroniser

// file: core/serial_frame_rx.sv
`timescale 1ns/10ps
// =============================================================
// serial control frame receiver, works on synchronised pins
module serial_frame_rx (
	input  wire logic                                  clk_sys,
	input  wire logic                                  rst_b,
	input  wire logic                                  sclkSync,
	input  wire logic                                  dinSync,
	input  wire logic                                  selSync_b,
	input  wire logic [adpcm_ctrl_pkg::REG_W-1:0]      readByte,
	output logic      [adpcm_ctrl_pkg::ADDR_W-1:0]     headerAddr,
	output logic                                       frameDone,
	output logic      [adpcm_ctrl_pkg::FRAME_MAIN-1:0] frameWord,
	output logic                                       serialOut,
	output logic                                       serialOutEn_b
);
	import adpcm_ctrl_pkg::*;

	typedef struct packed {
		logic                  clkPrev;
		logic                  selPrev;
		logic [FRAME_LONG-1:0] shift;
		logic [CNT_W-1:0]      count;
		logic                  done;
		logic                  loaded;
		logic                  reading;
		logic [REG_W-1:0]      shadow;
		logic                  outBit;
		logic                  outEn_b;
	} rx_s;

	rx_s s;
	rx_s n;

	// =============================================================
	// frame capture
	always_comb begin
		n         = s;
		n.done    = 1'b0;
		n.clkPrev = sclkSync;
		n.selPrev = selSync_b;
		if (selSync_b) begin
			n.count   = '0;
			n.loaded  = 1'b0;
			n.reading = 1'b0;
			n.outBit  = 1'b0;
			n.outEn_b = 1'b1;
			// R17 frame length check
			if (!s.selPrev && (s.count == FRAME_SHORT_C || s.count == FRAME_LONG_C)) begin
				n.done = 1'b1;
			end
		end else begin
			// R16 only edges inside frame
			if (sclkSync && !s.clkPrev) begin
				n.shift = {s.shift[FRAME_LONG-2:0], dinSync};
				if (s.count != CNT_MAX_C) begin
					n.count = s.count + 1'b1;
				end
				if (s.reading) begin
					n.outBit = s.shadow[REG_W-1];
					n.shadow = {s.shadow[REG_W-2:0], 1'b0};
				end
			end else if (s.count == HDR_C && !s.loaded) begin
				// header complete: latch read byte one cycle after its address settles
				n.loaded  = 1'b1;
				n.reading = s.shift[HDR_BITS-1];
				n.outEn_b = ~s.shift[HDR_BITS-1];
				n.outBit  = readByte[REG_W-1] & s.shift[HDR_BITS-1];
				n.shadow  = {readByte[REG_W-2:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s <= '{clkPrev: 1'b0, selPrev: 1'b1, shift: '0, count: '0, done: 1'b0,
				loaded: 1'b0, reading: 1'b0, shadow: '0, outBit: 1'b0, outEn_b: 1'b1};
		end else begin
			s <= n;
		end
	end

	assign headerAddr    = s.shift[ADDR_W-1:0];
	assign frameDone     = s.done;
	assign frameWord     = s.shift[FRAME_MAIN-1:0];
	assign serialOut     = s.outBit;
	assign serialOutEn_b = s.outEn_b;

	// =============================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	frameLength_a: assert property (s.done |-> ($past(s.count) == FRAME_SHORT_C // R17
		|| $past(s.count) == FRAME_LONG_C))
		else $error("frame accepted with bad length");
endmodule // serial_frame_rx

// file: pkg/adpcm_ctrl_pkg.sv
// =============================================================
// control register map and serial frame layout
package adpcm_ctrl_pkg;

	// =============================================================
	// widths
	localparam int REG_W      = 8;
	localparam int ADDR_W     = 3;
	localparam int FRAME_LONG = 16;
	localparam int FRAME_MAIN = 12;  // bits kept for decode
	localparam int HDR_BITS   = 4;
	localparam int CNT_W      = 5;
	localparam int GAIN_W     = 3;
	localparam int BITS_W     = 4;
	localparam int PIN_W      = 4;

	// frame lengths and bit counter limits
	localparam logic [CNT_W-1:0] FRAME_SHORT_C = 5'h0c;
	localparam logic [CNT_W-1:0] FRAME_LONG_C  = 5'h10;
	localparam logic [CNT_W-1:0] HDR_C         = 5'h04;
	localparam logic [CNT_W-1:0] CNT_MAX_C     = 5'h1f;

	// decode positions inside the last twelve bits of a frame
	localparam int FRM_RW_BIT   = 11;  // 1 = read
	localparam int FRM_ADDR_MSB = 10;
	localparam int FRM_ADDR_LSB = 8;
	localparam int FRM_DATA_MSB = 7;

	// register addresses
	localparam logic [ADDR_W-1:0] ADDR_POWER = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_MODE  = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_PATH  = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_SIDE  = 3'h3;

	// power_control fields
	localparam int PWR_PDN_BIT = 5;
	// adpcm_mode_control fields
	localparam int MODE_HI_BIT   = 7;
	localparam int MODE_LO_BIT   = 6;
	localparam int MODE_TXRST    = 5;
	localparam int MODE_RXRST    = 4;
	localparam int MODE_TXMUTE   = 3;
	localparam int MODE_RXMUTE   = 2;
	localparam int MODE_RXPAD    = 0;
	// pcm_path_gain_control fields
	localparam int PATH_TXOFF    = 7;
	localparam int PATH_TXG_LSB  = 4;
	localparam int PATH_RXOFF    = 3;
	localparam int PATH_RXG_LSB  = 0;
	// sidetone_filter_control fields
	localparam int SIDE_G_LSB    = 5;
	localparam int SIDE_HPF_CUT  = 1;
	localparam int SIDE_HPF_DIS  = 0;

	// reset values, don't care bits taken as zero
	localparam logic [REG_W-1:0] POWER_RST = 8'h00;
	localparam logic [REG_W-1:0] MODE_RST  = 8'h00;
	localparam logic [REG_W-1:0] PATH_RST  = 8'h33;
	localparam logic [REG_W-1:0] SIDE_RST  = 8'h00;

	localparam logic [GAIN_W-1:0] SIDETONE_OFF = 3'h0;

	// pin order {powerdown, select, data, clock}; powerdown held low at reset
	localparam logic [PIN_W-1:0] PIN_SYNC_RST = 4'h4;

	// code width select, implicit encoding 00,01,10,11
	typedef enum logic [1:0] {
		WIDTH_4BIT,
		WIDTH_8BIT,
		WIDTH_3BIT,
		WIDTH_2BIT
	} adpcm_width_e;

	localparam logic [BITS_W-1:0] BITS_4 = 4'h4;
	localparam logic [BITS_W-1:0] BITS_8 = 4'h8;
	localparam logic [BITS_W-1:0] BITS_3 = 4'h3;
	localparam logic [BITS_W-1:0] BITS_2 = 4'h2;

endpackage

// file: verification/adpcm_codec_control_regs_tb.sv
`timescale 1ns/10ps
// =============================================================
// self-checking bench for the control register bank
module adpcm_codec_control_regs_tb;
	import adpcm_ctrl_pkg::*;

	localparam int SAMPLE_CYC = 12500;  // one sample period at 8 kHz
	localparam int LIMIT_CYC  = 80000;  // run needs about 20000

	logic        clk_sys, rst_b, pdPin_b;
	logic        shiftClock, serialData, select_b, serOut, serOutEn_b;
	logic        devicePowerDown, txCoderReset, rxCoderReset, txAdpcmMute;
	logic        rxAdpcmMute, rxPadInsert, txPcmEnable, rxPcmEnable;
	logic        sidetoneOn, hpfCutoffLow, hpfEnable, enFault;
	logic [3:0]  adpcmBitsPerSample;
	logic [2:0]  txGainCode, rxGainCode, sidetoneGainCode;
	logic [7:0]  readBack;
	logic [7:0]  regS [4];
	logic [23:0] status;
	int          miscompares, nTests, cycles, c;

	// =============================================================
	// design and partner
	adpcm_codec_control_regs adpcm_codec_control_regs_i (
		.clk_sys(clk_sys), .rst_b(rst_b), .powerdown_reset_pin_b(pdPin_b),
		.shift_clock_in(shiftClock), .serial_control_input(serialData),
		.controlSelect_b(select_b), .serialControlOutput(serOut),
		.serialOutputEn_b(serOutEn_b), .devicePowerDown(devicePowerDown),
		.adpcmBitsPerSample(adpcmBitsPerSample), .txCoderReset(txCoderReset),
		.rxCoderReset(rxCoderReset), .txAdpcmMute(txAdpcmMute),
		.rxAdpcmMute(rxAdpcmMute), .rxPadInsert(rxPadInsert),
		.txPcmEnable(txPcmEnable), .rxPcmEnable(rxPcmEnable),
		.txGainCode(txGainCode), .rxGainCode(rxGainCode), .sidetoneOn(sidetoneOn),
		.sidetoneGainCode(sidetoneGainCode), .hpfCutoffLow(hpfCutoffLow),
		.hpfEnable(hpfEnable));

	mcu_serial_model mcu_serial_model_i (
		.clk_sys(clk_sys), .readData(serOut), .readEn_b(serOutEn_b),
		.shiftClock(shiftClock), .serialData(serialData), .select_b(select_b),
		.lastRead(readBack), .enFault(enFault));

	// all control outputs in one vector so one check covers every field
	assign status = {devicePowerDown, adpcmBitsPerSample, txCoderReset, rxCoderReset,
		txAdpcmMute, rxAdpcmMute, rxPadInsert, txPcmEnable, rxPcmEnable, txGainCode,
		rxGainCode, sidetoneOn, sidetoneGainCode, hpfCutoffLow, hpfEnable};

	always #5 clk_sys = ~clk_sys;

	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == LIMIT_CYC) begin
			miscompares++;
			test_done();
		end
	end

	// =============================================================
	// expected outputs from the shadow registers
	function automatic logic [23:0] expStatus();
		logic [3:0] bits;
		case (regS[1][7:6])
			2'b00: bits = BITS_4;
			2'b01: bits = BITS_8;
			2'b10: bits = BITS_3;
			default: bits = BITS_2;
		endcase
		return {regS[0][5] | ~pdPin_b, bits, regS[1][5:2], regS[1][0], ~regS[2][7],
			~regS[2][3], regS[2][6:4], regS[2][2:0], regS[3][7:5] != 3'h0,
			regS[3][7:5], regS[3][1], ~regS[3][0]};
	endfunction

	task automatic chk(input logic [23:0] got, input logic [23:0] want, input string what);
		nTests++;
		if (got !== want) begin
			miscompares++;
			$display("MISMATCH at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask

	// settle past the edge so the flops have landed
	task automatic checkAll(input string what);
		#1;
		chk(status, expStatus(), what);
	endtask

	task automatic resetShadow();
		regS[0] = POWER_RST;
		regS[1] = MODE_RST;
		regS[2] = PATH_RST;
		regS[3] = SIDE_RST;
	endtask

	task automatic writeReg(input logic [2:0] a, input logic [7:0] d);
		mcu_serial_model_i.sendFrame(12, {4'h0, 1'b0, a, d});
		if (a < 3'h4) regS[a[1:0]] = d;
	endtask

	task automatic readReg(input logic [2:0] a, input logic [7:0] want);
		mcu_serial_model_i.sendFrame(12, {4'h0, 1'b1, a, 8'h00});
		chk({16'h0000, readBack}, {16'h0000, want}, "read back");
		chk({23'h000000, enFault}, 24'h000000, "output enable");
	endtask

	// =============================================================
	// scenarios
	task automatic t_reset();
		checkAll("reset state");
		for (c = 0; c < 4; c++) readReg(3'(c), regS[c]);
	endtask

	task automatic t_mode();
		for (c = 0; c < 4; c++) begin
			writeReg(3'h1, {2'(c), 2'b00, 2'(3 - c), 1'b0, c[1]});
			checkAll("mode field");
		end
		writeReg(3'h1, 8'h30);
		checkAll("coder reset");
		repeat (SAMPLE_CYC) @(posedge clk_sys);
		writeReg(3'h1, 8'h00);
		checkAll("coder release");
	endtask

	task automatic t_path();
		for (c = 0; c < 8; c++) begin
			writeReg(3'h2, {c[0], 3'(c), c[1], 3'(7 - c)});
			checkAll("path gain");
		end
	endtask

	task automatic t_side();
		for (c = 0; c < 8; c++) begin
			writeReg(3'h3, {3'(c), 3'h0, c[1], c[2]});
			checkAll("sidetone filter");
		end
	endtask

	task automatic t_power();
		// pin held high while software controls power-down
		writeReg(3'h0, 8'h20);
		checkAll("power bit set");
		writeReg(3'h0, 8'h00);
		checkAll("power bit clear");
		writeReg(3'h1, 8'h0d);
		@(posedge clk_sys);
		pdPin_b <= 1'b0;
		repeat (20) @(posedge clk_sys);
		resetShadow();
		checkAll("pin reset");
		@(posedge clk_sys);
		pdPin_b <= 1'b1;
		repeat (8) @(posedge clk_sys);
		checkAll("after pin reset");
	endtask

	task automatic t_frames();
		mcu_serial_model_i.sendFrame(16, {4'h5, 1'b0, 3'h2, 8'hc6});
		regS[2] = 8'hc6;
		checkAll("long frame");
		mcu_serial_model_i.sendFrame(13, {3'h0, 13'h02ff});
		checkAll("13-bit frame");
		mcu_serial_model_i.sendFrame(11, 16'h02ff);
		checkAll("11-bit frame");
		writeReg(3'h5, 8'hff);
		checkAll("unmapped write");
		readReg(3'h5, 8'h00);
		readReg(3'h2, 8'hc6);
		mcu_serial_model_i.idleClocks(6);
		checkAll("idle clocks");
	endtask

	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// =============================================================
	// main sequence
	initial begin
		clk_sys     = 1'b0;
		rst_b       = 1'b0;
		pdPin_b     = 1'b1;
		miscompares = 0;
		nTests      = 0;
		cycles      = 0;
		resetShadow();
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk_sys);
		t_reset();
		t_mode();
		t_path();
		t_side();
		t_power();
		t_frames();
		test_done();
	end
endmodule // adpcm_codec_control_regs_tb

// file: verification/mcu_serial_model.sv
`timescale 1ns/10ps
// =============================================================
// microcontroller side of the serial control port
module mcu_serial_model (
	input  wire logic       clk_sys,
	input  wire logic       readData,
	input  wire logic       readEn_b,
	output logic            shiftClock,
	output logic            serialData,
	output logic            select_b,
	output logic [7:0]      lastRead,
	output logic            enFault
);
	// five clocks a phase clears the two-stage pin sync with margin
	localparam int PHASE = 5;

	// idle pins at time zero, shift clock parked low
	initial begin
		shiftClock = 1'b0;
		serialData = 1'b1;
		select_b   = 1'b1;
		lastRead   = 8'h00;
		enFault    = 1'b0;
	end

	task automatic waitClk(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// shift clock only runs inside a frame
	task automatic sendFrame(input int len, input logic [15:0] word);
		int p;
		waitClk(1);
		select_b <= 1'b0;
		for (p = 0; p < len; p++) begin
			waitClk(PHASE);
			serialData <= word[len-1-p];
			waitClk(PHASE);
			shiftClock <= 1'b1;
			// one extra clock: the first read bit only lands on the fifth clock after the edge
			waitClk(PHASE + 1);
			// read data taken just before the falling edge
			if (len == 12 && word[11] && p >= 3 && p <= 10) begin
				lastRead[10-p] <= readData;
				if (readEn_b !== 1'b0) enFault <= 1'b1;
			end else if (!word[11] && readEn_b !== 1'b1) begin
				enFault <= 1'b1;
			end
			shiftClock <= 1'b0;
		end
		waitClk(PHASE);
		select_b   <= 1'b1;
		// a released line shows the inverse, never a stale bit
		serialData <= ~serialData;
		waitClk(8);
	endtask

	// shift clock edges with select high, as a free-running clock would give
	task automatic idleClocks(input int n);
		repeat (n) begin
			waitClk(PHASE);
			shiftClock <= ~shiftClock;
		end
		waitClk(PHASE);
		shiftClock <= 1'b0;
	endtask
endmodule // mcu_serial_model
